//--- logic/cbs_sequencer.sv
/*
 * Complex breakpoint sequencer top: debug register port, six instruction
 * and two data breakpoint channels, priming routing, tuple and
 * qualification links, and the stopwatch timer.
 * Assumes the comparators present matches for the completing instruction
 * in the same cycle as retire_valid_i, and that trigger enables come from
 * the simple breakpoint registers held elsewhere.
 */
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic                       ref_clk_i,          // Core clk.
    input  wire logic                       reset_i,            // Sync rst.
    input  wire logic [cbs_pkg::ADDR_W-1:0] reg_addr_i,         // Offset.
    input  wire logic [31:0]                reg_wdata_i,        // Wr data.
    input  wire logic                       reg_wr_i,           // Wr strobe.
    input  wire logic                       reg_rd_i,           // Rd strobe.
    output logic [31:0]                     reg_rdata_o,        // Rd data.
    input  wire logic                       retire_valid_i,     // Completes.
    input  wire logic                       retire_exc_i,       // Excepts.
    input  wire logic                       debug_mode_i,       // In debug.
    input  wire logic [cbs_pkg::NUM_IBP-1:0] instr_match_i,     // I compare.
    input  wire logic [cbs_pkg::NUM_DBP-1:0] data_addr_match_i, // D addr.
    input  wire logic [cbs_pkg::NUM_DBP-1:0] data_value_match_i,// D value.
    input  wire logic [cbs_pkg::NUM_IBP-1:0] instr_trig_en_i,   // I trig en.
    input  wire logic [cbs_pkg::NUM_DBP-1:0] data_trig_en_i,    // D trig en.
    output logic [cbs_pkg::NUM_IBP-1:0]     instr_action_o,     // I action.
    output logic [cbs_pkg::NUM_DBP-1:0]     data_action_o,      // D action.
    output logic                            stopwatch_running_o // In run state.
);
    import cbs_pkg::*;

    // ************************************************************
    // Shared signals.
    // ************************************************************
    logic                   retire_ok;
    logic [NUM_BP-1:0]      bp_src;
    logic [NUM_IBP-1:0]     ifire;
    logic [NUM_IBP-1:0]     isrc_en;
    logic [NUM_DBP-1:0]     dfire;
    logic [NUM_DBP-1:0]     dsrc_en;
    logic [NUM_IBP-1:0]     imatch_raw;
    logic [31:0]            ictl_rd [NUM_IBP];
    logic [31:0]            ipc_rd  [NUM_IBP];
    logic [31:0]            dctl_rd [NUM_DBP];
    logic [31:0]            dpc_rd  [NUM_DBP];
    logic [31:0]            read_value;
    logic [31:0]            reg_rdata_reg;
    logic [NUM_IBP-1:0]     instr_action_reg;
    logic [NUM_DBP-1:0]     data_action_reg;
    logic [31:0]            sw_count_reg;
    logic                   sw_free_reg;
    cbs_sw_state_e          sw_state_reg;
    cbs_sw_state_e          sw_state_next;
    logic                   sw_start;
    logic                   sw_stop;

    // An instruction that raises an exception is invisible to all state.
    assign retire_ok  = retire_valid_i && !retire_exc_i;
    assign imatch_raw = instr_match_i;

    // ************************************************************
    // Instruction breakpoint channels.
    // ************************************************************
    for (genvar i = 0; i < NUM_IBP; i++)
    begin : gen_ibp
        localparam logic [15:0] OFS = 16'(i * 32'(CHAN_STRIDE));
        cbs_chan_if #(.CNT_W(IPC_W)) ich ();

        assign ich.match    = imatch_raw[i];
        assign ich.retire   = retire_ok;
        assign ich.ctl_wr   = reg_wr_i && (reg_addr_i == ICTL_BASE + OFS);
        assign ich.pc_wr    = reg_wr_i && (reg_addr_i == IPC_BASE + OFS);
        assign ich.wdata    = reg_wdata_i;
        // Condition zero never primes; others route a fixed source.
        assign ich.prime_in = (ich.prime_sel == 2'd0) ? 1'b0 :
                              bp_src[PRIME_SRC[i][ich.prime_sel]];
        // Fixed qualifier; it only counts if it can itself act.
        assign ich.qual_upd = data_addr_match_i[QUAL_DBP[i]] &&
                              dsrc_en[QUAL_DBP[i]];
        assign ich.qual_val = data_value_match_i[QUAL_DBP[i]];

        assign ifire[i]   = ich.fire;
        assign isrc_en[i] = instr_trig_en_i[i] || ich.cbe;
        // The gated match, not the raw one, is what primes others.
        assign bp_src[i]  = ich.fire && isrc_en[i];
        assign ictl_rd[i] = {16'h0000, 2'b00, ich.prime_sel, 3'b000,
                             ich.pc_en, 3'b000, ich.mode, 3'b000, ich.cbe};
        assign ipc_rd[i]  = {{(32 - IPC_W){1'b0}}, ich.pc};

        cbs_channel #(
            .CNT_W    (IPC_W),
            .HAS_QUAL (1'b1)
        ) u_chan (
            .ref_clk_i (ref_clk_i),
            .reset_i   (reset_i),
            .ch        (ich)
        );
    end

    // ************************************************************
    // Data breakpoint channels.
    // ************************************************************
    for (genvar d = 0; d < NUM_DBP; d++)
    begin : gen_dbp
        localparam logic [15:0] OFS = 16'(d * 32'(CHAN_STRIDE));
        cbs_chan_if #(.CNT_W(DPC_W)) dch ();

        // In tuple mode the fixed instruction comparator must agree too,
        // so the counter, priming and action below all see the AND.
        assign dch.match    = data_addr_match_i[d] &&
                              data_value_match_i[d] &&
                              (!dch.mode ||
                               imatch_raw[TUPLE_IBP[d]]);
        assign dch.retire   = retire_ok;
        assign dch.ctl_wr   = reg_wr_i && (reg_addr_i == DCTL_BASE + OFS);
        assign dch.pc_wr    = reg_wr_i && (reg_addr_i == DPC_BASE + OFS);
        assign dch.wdata    = reg_wdata_i;
        assign dch.prime_in = (dch.prime_sel == 2'd0) ? 1'b0 :
                              bp_src[PRIME_SRC[NUM_IBP + d][dch.prime_sel]];
        assign dch.qual_upd = 1'b0;
        assign dch.qual_val = 1'b0;

        assign dfire[d]   = dch.fire;
        assign dsrc_en[d] = data_trig_en_i[d] || dch.cbe;
        assign bp_src[NUM_IBP + d] = dch.fire && dsrc_en[d];
        assign dctl_rd[d] = {16'h0000, 2'b00, dch.prime_sel, 3'b000,
                             dch.pc_en, 3'b000, dch.mode, 3'b000, dch.cbe};
        assign dpc_rd[d]  = {{(32 - DPC_W){1'b0}}, dch.pc};

        cbs_channel #(
            .CNT_W    (DPC_W),
            .HAS_QUAL (1'b0)
        ) u_chan (
            .ref_clk_i (ref_clk_i),
            .reset_i   (reset_i),
            .ch        (dch)
        );
    end

    // ************************************************************
    // Breakpoint actions.
    // ************************************************************
    // Registering the action makes the break land on the instruction
    // after the match, which is why these exceptions are imprecise.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            instr_action_reg <= '0;
            data_action_reg  <= '0;
        end
        else
        begin
            instr_action_reg <= retire_ok ? ifire : '0;
            data_action_reg  <= retire_ok ? dfire : '0;
        end
    end

    // ************************************************************
    // Stopwatch timer.
    // ************************************************************
    // Only the fixed pair can start and stop it; its own enables gate it.
    assign sw_start = retire_ok && ifire[SW_START_IBP] &&
                      isrc_en[SW_START_IBP];
    assign sw_stop  = retire_ok && ifire[SW_STOP_IBP] &&
                      isrc_en[SW_STOP_IBP];

    // Run state under breakpoint control.
    always_comb
    begin
        sw_state_next = sw_state_reg;
        case (sw_state_reg)
            CBS_SW_STOP:
                if (sw_start)
                    sw_state_next = CBS_SW_RUN;
            CBS_SW_RUN:
                if (sw_stop)
                    sw_state_next = CBS_SW_STOP;
            default:
                sw_state_next = CBS_SW_STOP;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            sw_state_reg <= CBS_SW_STOP;
        else
            sw_state_reg <= sw_state_next;
    end

    // Mode bit: clear means breakpoint controlled, set means free running.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            sw_free_reg <= 1'b0;
        else if (reg_wr_i && (reg_addr_i == FEAT_OFS))
            sw_free_reg <= reg_wdata_i[FEAT_FREE_BIT];
    end

    // Count; a software load wins over the increment in the same cycle.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            sw_count_reg <= STOPWATCH_COUNT_RST;
        else if (reg_wr_i && (reg_addr_i == STOPWATCH_COUNT_OFS))
            sw_count_reg <= reg_wdata_i;
        else if ((sw_free_reg || (sw_state_reg == CBS_SW_RUN)) &&
                 !debug_mode_i)
            sw_count_reg <= sw_count_reg + 32'h0000_0001;
    end

    // ************************************************************
    // Register read path.
    // ************************************************************
    // Unmapped offsets read as zero; description registers are constant.
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (reg_addr_i == STOPWATCH_COUNT_OFS)
            read_value = sw_count_reg;
        else if (reg_addr_i == STOPWATCH_CONTROL_OFS)
            read_value = STOPWATCH_CONTROL_VAL;
        else if (reg_addr_i == FEAT_OFS)
            read_value = {31'h0000_0000, sw_free_reg};
        for (int i = 0; i < NUM_IBP; i++)
        begin
            if (reg_addr_i == ICTL_BASE + 16'(i * 32'(CHAN_STRIDE)))
                read_value = ictl_rd[i];
            if (reg_addr_i == IPC_BASE + 16'(i * 32'(CHAN_STRIDE)))
                read_value = ipc_rd[i];
            if (reg_addr_i == IPRD_BASE + 16'(i * 32'(CHAN_STRIDE)))
                read_value = PRIME_DESC[i];
        end
        for (int d = 0; d < NUM_DBP; d++)
        begin
            if (reg_addr_i == DCTL_BASE + 16'(d * 32'(CHAN_STRIDE)))
                read_value = dctl_rd[d];
            if (reg_addr_i == DPC_BASE + 16'(d * 32'(CHAN_STRIDE)))
                read_value = dpc_rd[d];
            if (reg_addr_i == DPRD_BASE + 16'(d * 32'(CHAN_STRIDE)))
                read_value = PRIME_DESC[NUM_IBP + d];
        end
    end

    // Read data is captured on the strobe and held until the next read.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            reg_rdata_reg <= 32'h0000_0000;
        else if (reg_rd_i)
            reg_rdata_reg <= read_value;
    end

    // ************************************************************
    // Outputs, all straight from flip-flops.
    // ************************************************************
    assign reg_rdata_o         = reg_rdata_reg;
    assign instr_action_o      = instr_action_reg;
    assign data_action_o       = data_action_reg;
    // One-hot state: the run bit itself is the flip-flop output.
    assign stopwatch_running_o = sw_state_reg[1];
endmodule

//--- logic/cbs_pkg.sv
/*
 * Shared constants for the complex breakpoint sequencer: channel counts,
 * debug register offsets, field positions, reset values and the fixed
 * priming, qualification and tuple maps.
 * Assumes the debug segment offset is presented as a 16-bit byte offset.
 */
package cbs_pkg;

    // ************************************************************
    // Channel counts and widths.
    // ************************************************************
    localparam int NUM_IBP = 6;
    localparam int NUM_DBP = 2;
    localparam int NUM_BP  = 8;
    localparam int IPC_W   = 8;
    localparam int DPC_W   = 16;
    localparam int ADDR_W  = 16;

    // ************************************************************
    // Register offsets; per-channel registers step by a stride.
    // ************************************************************
    localparam logic [15:0] STOPWATCH_CONTROL_OFS    = 16'h8900;
    localparam logic [15:0] STOPWATCH_COUNT_OFS    = 16'h8908;
    localparam logic [15:0] FEAT_OFS     = 16'h8A00;
    localparam logic [15:0] IPRD_BASE    = 16'h8300;
    localparam logic [15:0] DPRD_BASE    = 16'h84E0;
    localparam logic [15:0] ICTL_BASE    = 16'h8600;
    localparam logic [15:0] IPC_BASE     = 16'h8604;
    localparam logic [15:0] DCTL_BASE    = 16'h8800;
    localparam logic [15:0] DPC_BASE     = 16'h8804;
    localparam logic [15:0] CHAN_STRIDE  = 16'h0020;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int CTL_CBE_BIT   = 0;
    localparam int CTL_MODE_BIT  = 4;
    localparam int CTL_PCEN_BIT  = 8;
    localparam int CTL_PRIMING_SELECT_LSB = 12;
    localparam int FEAT_FREE_BIT = 0;
    localparam logic [31:0] STOPWATCH_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] STOPWATCH_CONTROL_VAL = 32'h0000_0083;

    // ************************************************************
    // Fixed maps. Breakpoint index: 0-5 instruction, 6-7 data.
    // ************************************************************
    localparam int PRIME_SRC [NUM_BP][4] = '{
        '{0, 6, 1, 2}, '{0, 6, 0, 2}, '{0, 6, 0, 1}, '{0, 7, 4, 5},
        '{0, 7, 3, 5}, '{0, 7, 3, 4}, '{0, 0, 1, 2}, '{0, 3, 4, 5}};
    localparam logic [31:0] PRIME_DESC [NUM_BP] = '{
        32'h1211_2000, 32'h1210_2000, 32'h1110_2000, 32'h1514_2100,
        32'h1513_2100, 32'h1413_2100, 32'h1211_1000, 32'h1514_1300};
    localparam int QUAL_DBP  [NUM_IBP] = '{0, 0, 0, 1, 1, 1};
    localparam int TUPLE_IBP [NUM_DBP] = '{0, 3};
    localparam int SW_START_IBP = 1;
    localparam int SW_STOP_IBP  = 4;

    typedef enum logic [1:0]
    {
        CBS_SW_STOP = 2'b01,
        CBS_SW_RUN  = 2'b10
    } cbs_sw_state_e;

endpackage

//--- logic/cbs_chan_if.sv
/*
 * Carrier between the sequencer top and one breakpoint channel.
 * Assumes the top drives all control inputs from its own clock domain.
 */
interface cbs_chan_if #(parameter int CNT_W = 8);
    logic             match;
    logic             retire;
    logic             ctl_wr;
    logic             pc_wr;
    logic [31:0]      wdata;
    logic             prime_in;
    logic             qual_upd;
    logic             qual_val;
    logic             cbe;
    logic             mode;
    logic [1:0]       prime_sel;
    logic [CNT_W-1:0] pc;
    logic             pc_en;
    logic             primed;
    logic             qualified;
    logic             fire;

    modport top (output match, retire, ctl_wr, pc_wr, wdata, prime_in,
                 qual_upd, qual_val,
                 input cbe, mode, prime_sel, pc, pc_en, primed,
                 qualified, fire);
    modport chan (input match, retire, ctl_wr, pc_wr, wdata, prime_in,
                  qual_upd, qual_val,
                  output cbe, mode, prime_sel, pc, pc_en, primed,
                  qualified, fire);
endinterface

//--- logic/cbs_channel.sv
/*
 * One breakpoint channel: complex control, pass counter, primed state and
 * data qualification state. Produces the gated match that drives actions.
 * Assumes retire is already blocked for exceptional instructions.
 */
module cbs_channel
#(
    parameter int CNT_W    = 8,
    parameter bit HAS_QUAL = 1'b1
)
(
    input  wire logic  ref_clk_i,   // Core clock.
    input  wire logic  reset_i,     // Synchronous reset, high.
    cbs_chan_if.chan   ch           // Link to the top.
);
    import cbs_pkg::*;

    logic prime_ok;
    logic qual_ok;
    logic eligible;

    // ************************************************************
    // Gating of the raw comparator match.
    // ************************************************************
    assign prime_ok = (ch.prime_sel == 2'd0) || ch.primed;
    // Data channels use the mode bit as the tuple bit instead.
    assign qual_ok  = !HAS_QUAL || !ch.mode || ch.qualified;
    assign eligible = ch.match && prime_ok && qual_ok;
    // No action on the match that counts from one to zero.
    assign ch.fire  = eligible && (ch.pc == '0);

    // Complex control fields; all clear at reset so nothing is enabled.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            ch.cbe       <= 1'b0;
            ch.mode      <= 1'b0;
            ch.prime_sel <= 2'd0;
        end
        else if (ch.ctl_wr)
        begin
            ch.cbe       <= ch.wdata[CTL_CBE_BIT];
            ch.mode      <= ch.wdata[CTL_MODE_BIT];
            ch.prime_sel <= ch.wdata[CTL_PRIMING_SELECT_LSB +: 2];
        end
    end

    // Pass counter; a software load takes priority over counting.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            ch.pc    <= '0;
            ch.pc_en <= 1'b0;
        end
        else if (ch.pc_wr)
        begin
            ch.pc    <= ch.wdata[CNT_W-1:0];
            ch.pc_en <= (ch.wdata[CNT_W-1:0] != '0);
        end
        else if (ch.retire && eligible && (ch.pc != '0))
        begin
            ch.pc <= ch.pc - 1'b1;
        end
    end

    // Primed state lives here; a priming event beats a clearing write.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            ch.primed <= 1'b0;
        else if (ch.retire && ch.prime_in)
            ch.primed <= 1'b1;
        else if (ch.ctl_wr)
            ch.primed <= 1'b0;
    end

    // Qualified state: a qualifier address match sets or clears it.
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            ch.qualified <= 1'b0;
        else if (HAS_QUAL && ch.retire && ch.qual_upd)
            ch.qualified <= ch.qual_val;
        else if (ch.ctl_wr)
            ch.qualified <= 1'b0;
    end
endmodule

//--- tb/cbs_sequencer_asserts.sv
/*
 * Port checker for the complex breakpoint sequencer top.
 * Assumes a bind from the bench top and the single core clock.
 */
module cbs_sequencer_asserts
    import cbs_pkg::*;
(
    input wire logic                        ref_clk_i,         // Clock.
    input wire logic                        reset_i,           // Reset.
    input wire logic                        reg_rd_i,          // Read.
    input wire logic [31:0]                 reg_rdata_o,       // Data.
    input wire logic                        retire_valid_i,    // Retire.
    input wire logic                        retire_exc_i,      // Except.
    input wire logic [cbs_pkg::NUM_IBP-1:0] instr_match_i,     // I hit.
    input wire logic [cbs_pkg::NUM_DBP-1:0] data_addr_match_i, // D hit.
    input wire logic [cbs_pkg::NUM_IBP-1:0] instr_action_o,    // I act.
    input wire logic [cbs_pkg::NUM_DBP-1:0] data_action_o,     // D act.
    input wire logic                        stopwatch_running_o // Run.
);
    timeunit 1ns;
    timeprecision 1ps;

    // All checks share the core clock and its reset.
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_exc_quiet: assert property (retire_valid_i && retire_exc_i
        |=> {instr_action_o, data_action_o} == '0) else $error("exc act");
    a_act_late: assert property (|instr_action_o
        |-> $past(retire_valid_i && !retire_exc_i)) else $error("late");
    a_imatch_cause: assert property (
        (instr_action_o & ~$past(instr_match_i)) == '0) else $error("i act");
    a_dmatch_cause: assert property (
        (data_action_o & ~$past(data_addr_match_i)) == '0)
        else $error("d act");
    a_reset_idle: assert property ($fell(reset_i)
        |-> !stopwatch_running_o && {instr_action_o, data_action_o} == '0)
        else $error("not idle");
    a_sw_start: assert property ($rose(stopwatch_running_o)
        |-> $past(instr_match_i[SW_START_IBP])
            || $past(instr_match_i[SW_START_IBP], 2)) else $error("start");
    a_sw_stop: assert property ($fell(stopwatch_running_o)
        |-> $past(instr_match_i[SW_STOP_IBP])
            || $past(instr_match_i[SW_STOP_IBP], 2)) else $error("stop");
    a_rdata_hold: assert property (!reg_rd_i
        |=> $stable(reg_rdata_o)) else $error("rdata moved");
endmodule

//--- tb/cbs_pipe_model.sv
/*
 * Completion stage model: retires one instruction with its matches.
 * Assumes the bench calls retire and nothing else drives these lines.
 */
module cbs_pipe_model
    import cbs_pkg::*;
(
    input  wire logic                   ref_clk_i, // Clock.
    output logic                        valid_o,   // Retire.
    output logic                        exc_o,     // Exception.
    output logic [cbs_pkg::NUM_IBP-1:0] im_o,      // I match.
    output logic [cbs_pkg::NUM_DBP-1:0] da_o,      // D address.
    output logic [cbs_pkg::NUM_DBP-1:0] dv_o       // D value.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {valid_o, exc_o, im_o, da_o, dv_o} = '0;

    // Outside a retire cycle the lines carry inverted garbage, so the
    // sequencer cannot lean on stale comparator values.
    task automatic retire(input logic [NUM_IBP-1:0] m,
                          input logic [3:0] d, input logic e);
        @(negedge ref_clk_i);
        {valid_o, exc_o, im_o, da_o, dv_o} = {1'b1, e, m, d};
        @(negedge ref_clk_i);
        {valid_o, exc_o, im_o, da_o, dv_o} = {1'b0, ~e, ~m, ~d};
    endtask
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench for the complex breakpoint sequencer.
 * Assumes the checker and pipeline model are compiled before it.
 */
module tb_top
    import cbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic debug_mode_i = 1, valid, exc, run;
    logic [15:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o;
    logic [NUM_IBP-1:0] im, ia, ite = '0;
    logic [NUM_DBP-1:0] da, dv, dact, dte = '0;
    logic [7:0] msk = 8'hFF;
    int fails = 0, tests_run = 0;

    // A 125 MHz core clock.
    always #4 ref_clk_i = ~ref_clk_i;

    cbs_sequencer DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .retire_valid_i(valid),
        .retire_exc_i(exc), .debug_mode_i(debug_mode_i),
        .instr_match_i(im), .data_addr_match_i(da),
        .data_value_match_i(dv), .instr_trig_en_i(ite),
        .data_trig_en_i(dte), .instr_action_o(ia),
        .data_action_o(dact), .stopwatch_running_o(run));
    cbs_pipe_model P (.ref_clk_i(ref_clk_i), .valid_o(valid),
        .exc_o(exc), .im_o(im), .da_o(da), .dv_o(dv));

    // ********************************************************
    // Access and compare tasks; all driving happens at negedge.
    // ********************************************************
    task automatic check(input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge ref_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge ref_clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(negedge ref_clk_i);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge ref_clk_i);
        reg_rd_i = 0;
        check(reg_rdata_o, e);
    endtask
    // The action pulse is looked at in the one cycle it stands.
    task automatic ret(input logic [5:0] m, input logic [3:0] d,
                       input logic e, input logic [7:0] x);
        P.retire(m, d, e);
        check({24'h0, {dact, ia} & msk}, {24'h0, x & msk});
    endtask
    task automatic do_reset();
        @(negedge ref_clk_i);
        reset_i = 1;
        repeat (3) @(negedge ref_clk_i);
        reset_i = 0;
    endtask
    // Leaves debug mode for exactly two clock edges.
    task automatic let_run();
        @(negedge ref_clk_i);
        debug_mode_i = 0;
        repeat (2) @(negedge ref_clk_i);
        debug_mode_i = 1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Cuts a hang short; the tests need only about 140 cycles.
    initial
    begin
        #100000;
        fails++;
        complete_run();
    end

    // ********************************************************
    // Test sequence.
    // ********************************************************
    initial
    begin
        do_reset();
        rd(STOPWATCH_COUNT_OFS, STOPWATCH_COUNT_RST);
        rd(STOPWATCH_CONTROL_OFS, STOPWATCH_CONTROL_VAL);
        rd(16'h0000, 32'h0);
        for (int k = 0; k < NUM_BP; k++)
            rd(k < NUM_IBP ? 16'(IPRD_BASE + CHAN_STRIDE * k)
               : 16'(DPRD_BASE + CHAN_STRIDE * (k - NUM_IBP)),
               PRIME_DESC[k]);
        wr(IPC_BASE, 32'hFFFF_FFFF);
        rd(IPC_BASE, 32'hFF);
        wr(DPC_BASE, 32'hFFFF_FFFF);
        rd(DPC_BASE, 32'hFFFF);
        wr(STOPWATCH_COUNT_OFS, 32'hFFFF_FFFF);
        let_run();
        rd(STOPWATCH_COUNT_OFS, 32'hFFFF_FFFF);
        wr(FEAT_OFS, 32'h1);
        let_run();
        rd(STOPWATCH_COUNT_OFS, 32'h1);
        $display("test registers done");
        do_reset();
        rd(IPC_BASE, 32'h0);
        wr(IPC_BASE, 32'h2);
        rd(ICTL_BASE, 32'h100);
        ret(6'h01, 4'h0, 1'b1, 8'h00);
        rd(IPC_BASE, 32'h2);
        ret(6'h01, 4'h0, 1'b0, 8'h00);
        rd(IPC_BASE, 32'h1);
        ret(6'h01, 4'h0, 1'b0, 8'h00);
        ret(6'h01, 4'h0, 1'b0, 8'h01);
        ret(6'h01, 4'h0, 1'b0, 8'h01);
        rd(ICTL_BASE, 32'h100);
        $display("test pass counter done");
        do_reset();
        wr(ICTL_BASE + CHAN_STRIDE, 32'h2000);
        ret(6'h02, 4'h0, 1'b0, 8'h00);
        ret(6'h01, 4'h0, 1'b0, 8'h01);
        ret(6'h02, 4'h0, 1'b0, 8'h00);
        ite = 6'h01;
        ret(6'h01, 4'h0, 1'b0, 8'h01);
        ret(6'h02, 4'h0, 1'b0, 8'h02);
        ret(6'h02, 4'h0, 1'b0, 8'h02);
        wr(ICTL_BASE + CHAN_STRIDE, 32'h2000);
        ret(6'h02, 4'h0, 1'b0, 8'h00);
        do_reset();
        ite = 6'h12;
        ret(6'h02, 4'h0, 1'b0, 8'h02);
        @(negedge ref_clk_i);
        check(run, 32'h1);
        ret(6'h10, 4'h0, 1'b0, 8'h10);
        @(negedge ref_clk_i);
        check(run, 32'h0);
        $display("test priming and timer done");
        do_reset();
        ite = 6'h00;
        msk = 8'hC0;
        wr(ICTL_BASE, 32'h1);
        wr(DCTL_BASE, 32'h10);
        wr(DPC_BASE, 32'h1);
        ret(6'h00, 4'h5, 1'b0, 8'h00);
        rd(DPC_BASE, 32'h1);
        ret(6'h01, 4'h5, 1'b0, 8'h00);
        ret(6'h01, 4'h5, 1'b0, 8'h40);
        do_reset();
        msk = 8'h3F;
        dte = 2'h1;
        wr(ICTL_BASE + 16'h0040, 32'h10);
        ret(6'h04, 4'h0, 1'b0, 8'h00);
        ret(6'h00, 4'h5, 1'b0, 8'h00);
        ret(6'h04, 4'h0, 1'b0, 8'h04);
        ret(6'h00, 4'h4, 1'b0, 8'h00);
        ret(6'h04, 4'h0, 1'b0, 8'h00);
        $display("test tuple and qualify done");
        complete_run();
    end
endmodule

bind cbs_sequencer cbs_sequencer_asserts CHK (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .retire_valid_i(retire_valid_i), .retire_exc_i(retire_exc_i),
    .instr_match_i(instr_match_i), .data_addr_match_i(data_addr_match_i),
    .instr_action_o(instr_action_o), .data_action_o(data_action_o),
    .stopwatch_running_o(stopwatch_running_o));
